// ### bcc_map.svh
`ifndef BCC_MAP_SVH
`define BCC_MAP_SVH

// Byte addresses of the counter registers.
`define BCC_SEC_ADDR      20'hFFF92
`define BCC_MIN_ADDR      20'hFFF93
`define BCC_HOUR_ADDR     20'hFFF94
`define BCC_WEEK_ADDR     20'hFFF95
`define BCC_DAY_ADDR      20'hFFF96
`define BCC_MONTH_ADDR    20'hFFF97
`define BCC_YEAR_ADDR     20'hFFF98

// Reset values of the counters.
`define BCC_SEC_RST       8'h00
`define BCC_MIN_RST       8'h00
`define BCC_HOUR_RST      8'h12
`define BCC_WEEK_RST      8'h00
`define BCC_DAY_RST       8'h01
`define BCC_MONTH_RST     8'h01
`define BCC_YEAR_RST      8'h00

// Implemented bits of each counter; the rest read zero.
`define BCC_SEC_MASK      8'h7F
`define BCC_MIN_MASK      8'h7F
`define BCC_HOUR_MASK     8'h3F
`define BCC_WEEK_MASK     8'h07
`define BCC_DAY_MASK      8'h3F
`define BCC_MONTH_MASK    8'h1F
`define BCC_YEAR_MASK     8'hFF

// Position of the afternoon flag in the hour value.
`define BCC_PM_BIT        5

// Clock rates and the derived count-clock divider.
`define BCC_SYS_CLK_HZ    50000000
`define BCC_COUNT_CLK_HZ  32768
`define BCC_COUNT_DIV     ((`BCC_SYS_CLK_HZ) / (`BCC_COUNT_CLK_HZ))

// Prescaler value at which one second has elapsed.
`define BCC_PRESCALE_TOP  16'h7FFF

`endif

// ### bcc_pkg.sv
package bcc_pkg;

   // One register byte.
   typedef logic [7:0] bcc_byte_t;

   // One-hot register select.
   typedef enum logic [6:0] {
      BCC_SEL_SEC   = 7'h01,
      BCC_SEL_MIN   = 7'h02,
      BCC_SEL_HOUR  = 7'h04,
      BCC_SEL_WEEK  = 7'h08,
      BCC_SEL_DAY   = 7'h10,
      BCC_SEL_MONTH = 7'h20,
      BCC_SEL_YEAR  = 7'h40
   } bcc_sel_t;

endpackage

// ### bcc_tick_div.sv
`timescale 1ns/1ns
`include "bcc_map.svh"

// Divides the system clock down to the count-clock enable pulse.
module bcc_tick_div #(
   parameter int DIV = `BCC_COUNT_DIV   // System cycles per count cycle.
) (
   input  wire logic sys_clk,    // System clock.
   input  wire logic rst,        // Asynchronous reset, active high.
   output logic      countTick   // One-cycle count-clock enable.
);

   logic [11:0] divCount;        // Cycles since the last tick.
   logic        divEnd;          // Last cycle of a count period.

   assign divEnd = (divCount == 12'(DIV - 1));

   // The counter wraps and issues one tick per period.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         divCount  <= 12'h000;
         countTick <= 1'b0;
      end else begin
         divCount  <= divEnd ? 12'h000 : divCount + 12'h001;
         countTick <= divEnd;
      end
   end

endmodule

// ### bcc_prescaler.sv
`timescale 1ns/1ns
`include "bcc_map.svh"

// Sixteen-bit prescaler that yields one overflow per second.
module bcc_prescaler #(
   parameter logic [15:0] TOP = `BCC_PRESCALE_TOP   // Count at which it overflows.
) (
   input  wire logic sys_clk,     // System clock.
   input  wire logic rst,         // Asynchronous reset, active high.
   input  wire logic countTick,   // Count-clock enable.
   input  wire logic runEnable,   // Counting allowed.
   input  wire logic clearCount,  // Clears the count to zero.
   output logic      overflow     // One-cycle overflow pulse.
);

   logic [15:0] preCount;         // Running count.
   logic        atTop;            // Count has reached its end.

   assign atTop    = (preCount == TOP);
   assign overflow = countTick & runEnable & atTop & ~clearCount;

   // Clear has priority so a seconds write restarts a full second.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         preCount <= 16'h0000;
      end else if (clearCount) begin
         preCount <= 16'h0000;
      end else if (countTick && runEnable) begin
         preCount <= atTop ? 16'h0000 : preCount + 16'h0001;
      end
   end

endmodule

// ### bcc_calendar_chain.sv
`timescale 1ns/1ns
`include "bcc_map.svh"

module bcc_calendar_chain #(
   parameter int DIV = `BCC_COUNT_DIV   // System cycles per count cycle.
) (
   input  wire logic             sys_clk,            // System clock, 50 MHz.
   input  wire logic             rst,                // Asynchronous reset, active high.
   input  wire logic [19:0]      regAddr,            // Register byte address.
   input  wire logic             regWrite,           // Byte write strobe.
   input  wire logic             regRead,            // Byte read strobe.
   input  wire bcc_pkg::bcc_byte_t regWdata,         // Write data.
   output bcc_pkg::bcc_byte_t    regRdata,           // Read data, registered.
   input  wire logic             counterRunEnable,   // Counting enabled.
   input  wire logic             hourFormatSelect,   // 1 selects 24-hour format.
   input  wire logic             counterHoldRequest, // Request to freeze counters.
   output logic                  counterHoldStatus   // Counters frozen for access.
);
   import bcc_pkg::*;

   // Converts a BCD byte to binary.
   function automatic logic [6:0] bcd2bin(input logic [7:0] v);
      bcd2bin = 7'(v[7:4]) * 7'd10 + 7'(v[3:0]);
   endfunction

   // Converts a binary value below 100 to a BCD byte.
   function automatic logic [7:0] bin2bcd(input logic [6:0] b);
      bin2bcd = {4'(b / 7'd10), 4'(b % 7'd10)};
   endfunction

   // Turns a 12-hour value into a 24-hour binary hour.
   function automatic logic [6:0] hour12To24(input logic [7:0] h);
      logic [6:0] d;
      d = bcd2bin({3'b000, h[4:0]});
      if (h[`BCC_PM_BIT]) begin
         hour12To24 = (d == 7'd12) ? d : d + 7'd12;
      end else begin
         hour12To24 = (d == 7'd12) ? 7'd0 : d;
      end
   endfunction

   // Turns a 24-hour binary hour into the 12-hour code.
   function automatic logic [7:0] hour24To12(input logic [6:0] d);
      if (d == 7'd0) begin
         hour24To12 = 8'h12;
      end else if (d < 7'd12) begin
         hour24To12 = bin2bcd(d);
      end else if (d == 7'd12) begin
         hour24To12 = 8'h32;
      end else begin
         hour24To12 = bin2bcd(d - 7'd12) | 8'h20;
      end
   endfunction

   // Adds one to a BCD byte.
   function automatic logic [7:0] bcdInc(input logic [7:0] v);
      bcdInc = bin2bcd(bcd2bin(v) + 7'd1);
   endfunction

   logic countTick;          // Count-clock enable.
   logic preOverflow;        // Prescaler overflow pulse.

   // Count-clock enable from the system clock.
   bcc_tick_div #(
      .DIV (DIV)
   ) u_div (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .countTick (countTick)
   );

   // Live counters.
   bcc_byte_t sec;           // Seconds.
   bcc_byte_t min;           // Minutes.
   bcc_byte_t hour;          // Hours.
   bcc_byte_t week;          // Weekday.
   bcc_byte_t day;           // Day of month.
   bcc_byte_t month;         // Month.
   bcc_byte_t year;          // Year.

   // Holding buffers for software writes.
   bcc_byte_t pendData [7];  // Buffered write data.
   logic [6:0] pendValid;    // Buffer awaits transfer.
   logic       ovfPend;      // Overflow seen during hold.
   logic       fmtSeen;      // Format the hour is stored in.

   // Address decode.
   logic [6:0] hitVec;       // One-hot address match.
   bcc_sel_t   regSel;       // Decoded register select.
   assign hitVec[0] = (regAddr == `BCC_SEC_ADDR);
   assign hitVec[1] = (regAddr == `BCC_MIN_ADDR);
   assign hitVec[2] = (regAddr == `BCC_HOUR_ADDR);
   assign hitVec[3] = (regAddr == `BCC_WEEK_ADDR);
   assign hitVec[4] = (regAddr == `BCC_DAY_ADDR);
   assign hitVec[5] = (regAddr == `BCC_MONTH_ADDR);
   assign hitVec[6] = (regAddr == `BCC_YEAR_ADDR);
   assign regSel    = bcc_sel_t'(hitVec);

   // Masks of implemented bits, per register index.
   logic [7:0] maskTab [7];  // Implemented-bit masks.
   assign maskTab[0] = `BCC_SEC_MASK;
   assign maskTab[1] = `BCC_MIN_MASK;
   assign maskTab[2] = `BCC_HOUR_MASK;
   assign maskTab[3] = `BCC_WEEK_MASK;
   assign maskTab[4] = `BCC_DAY_MASK;
   assign maskTab[5] = `BCC_MONTH_MASK;
   assign maskTab[6] = `BCC_YEAR_MASK;

   // Transfer strobes: a buffer lands at the next count tick.
   logic ldSec, ldMin, ldHour, ldWeek, ldDay, ldMon, ldYear;   // Load strobes.
   assign ldSec  = countTick & pendValid[0];
   assign ldMin  = countTick & pendValid[1];
   assign ldHour = countTick & pendValid[2];
   assign ldWeek = countTick & pendValid[3];
   assign ldDay  = countTick & pendValid[4];
   assign ldMon  = countTick & pendValid[5];
   assign ldYear = countTick & pendValid[6];

   // Prescaler; a seconds transfer restarts it.
   bcc_prescaler u_pre (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .countTick  (countTick),
      .runEnable  (counterRunEnable),
      .clearCount (ldSec),
      .overflow   (preOverflow)
   );

   // Derived calendar facts.
   logic       fmtChange;    // Format bit differs from stored format.
   logic       isLeap;       // Current year is a leap year.
   logic [7:0] dayLimit;     // Last day of the current month.
   logic [6:0] hour24;       // Current hour as 24-hour binary.
   assign fmtChange = countTick & (hourFormatSelect != fmtSeen);
   assign isLeap    = (2'(year[1:0]) + {year[4], 1'b0}) == 2'b00;
   assign hour24    = fmtSeen ? bcd2bin(hour) : hour12To24(hour);
   assign dayLimit  = (month == 8'h02) ? (isLeap ? 8'h29 : 8'h28) :
                      (month == 8'h04 || month == 8'h06 ||
                       month == 8'h09 || month == 8'h11) ? 8'h30 : 8'h31;

   // Carry chain; a load in the same tick swallows the carry.
   logic adv;                                    // Seconds advance.
   logic minInc, hourInc, dayInc, monInc, yearInc;          // Increments.
   logic secCarry, minCarry, hourCarry, dayCarry, monCarry; // Rollovers.
   assign adv       = countTick & counterRunEnable & ~counterHoldStatus
                      & (preOverflow | ovfPend);
   assign secCarry  = adv & (sec == 8'h59) & ~ldSec;
   assign minInc    = secCarry & ~ldMin;
   assign minCarry  = minInc & (min == 8'h59);
   assign hourInc   = minCarry & ~ldHour;
   assign hourCarry = hourInc & (hour24 == 7'd23);
   assign dayInc    = hourCarry & ~ldDay;
   assign dayCarry  = dayInc & (day >= dayLimit);
   assign monInc    = dayCarry & ~ldMon;
   assign monCarry  = monInc & (month == 8'h12);
   assign yearInc   = monCarry & ~ldYear;

   // Next hour in the selected format, which differs from the stored one only on a format change.
   logic [6:0] hourNext24;   // Next hour as 24-hour binary.
   logic [7:0] hourStep;     // Incremented hour code.
   logic [7:0] hourConv;     // Hour converted to the new format.
   assign hourNext24 = (hour24 == 7'd23) ? 7'd0 : hour24 + 7'd1;
   assign hourStep   = hourFormatSelect ? bin2bcd(hourNext24) : hour24To12(hourNext24);
   assign hourConv   = hourFormatSelect ? bin2bcd(hour24) : hour24To12(hour24);

   // Next counter values.
   bcc_byte_t next_sec, next_min, next_hour, next_week;   // Next values.
   bcc_byte_t next_day, next_month, next_year;            // Next values.
   assign next_sec   = ldSec  ? pendData[0] :
                       adv ? ((sec == 8'h59) ? 8'h00 : bcdInc(sec)) : sec;
   assign next_min   = ldMin  ? pendData[1] :
                       minInc ? ((min == 8'h59) ? 8'h00 : bcdInc(min)) : min;
   // A step in the tick of a format change lands in the new format, so no hour is lost.
   assign next_hour  = ldHour ? pendData[2] : hourInc ? hourStep :
                       fmtChange ? hourConv : hour;
   assign next_week  = ldWeek ? pendData[3] :
                       dayInc ? ((week == 8'h06) ? 8'h00 : week + 8'h01) : week;
   assign next_day   = ldDay  ? pendData[4] :
                       dayInc ? ((day >= dayLimit) ? 8'h01 : bcdInc(day)) : day;
   assign next_month = ldMon  ? pendData[5] :
                       monInc ? ((month == 8'h12) ? 8'h01 : bcdInc(month)) : month;
   assign next_year  = ldYear ? pendData[6] :
                       yearInc ? ((year == 8'h99) ? 8'h00 : bcdInc(year)) : year;

   // Counter registers load their reset values and then their next values.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sec   <= `BCC_SEC_RST;
         min   <= `BCC_MIN_RST;
         hour  <= `BCC_HOUR_RST;
         week  <= `BCC_WEEK_RST;
         day   <= `BCC_DAY_RST;
         month <= `BCC_MONTH_RST;
         year  <= `BCC_YEAR_RST;
      end else begin
         sec   <= next_sec;
         min   <= next_min;
         hour  <= next_hour;
         week  <= next_week;
         day   <= next_day;
         month <= next_month;
         year  <= next_year;
      end
   end

   // Tracks the stored format; reset leaves 12-hour so 24-hour shows 00H.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fmtSeen <= 1'b0;
      end else if (fmtChange) begin
         fmtSeen <= hourFormatSelect;
      end
   end

   // Write buffers capture whole masked bytes; a new write beats the transfer.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pendValid <= 7'h00;
         for (int i = 0; i < 7; i++) begin
            pendData[i] <= 8'h00;
         end
      end else begin
         for (int i = 0; i < 7; i++) begin
            if (regWrite && hitVec[i]) begin
               pendData[i]  <= regWdata & maskTab[i];
               pendValid[i] <= 1'b1;
            end else if (countTick) begin
               pendValid[i] <= 1'b0;
            end
         end
      end
   end

   // Hold status follows the request at each count tick.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         counterHoldStatus <= 1'b0;
      end else if (countTick) begin
         counterHoldStatus <= counterHoldRequest;
      end
   end

   // Overflow memory across a hold; a seconds load discards it.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ovfPend <= 1'b0;
      end else if (ldSec) begin
         ovfPend <= 1'b0;
      end else if (preOverflow && counterHoldStatus) begin
         ovfPend <= 1'b1;
      end else if (adv) begin
         ovfPend <= 1'b0;
      end
   end

   // Read multiplexer over the live counters.
   bcc_byte_t readMux;       // Selected counter value.
   always_comb begin
      unique case (regSel)
         BCC_SEL_SEC:   readMux = sec;
         BCC_SEL_MIN:   readMux = min;
         BCC_SEL_HOUR:  readMux = hour;
         BCC_SEL_WEEK:  readMux = week;
         BCC_SEL_DAY:   readMux = day;
         BCC_SEL_MONTH: readMux = month;
         BCC_SEL_YEAR:  readMux = year;
         default:       readMux = 8'h00;   // Unmapped address reads zero.
      endcase
   end

   // Read data register, updated on each read strobe.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         regRdata <= readMux;
      end
   end

endmodule

// ### bcc_calendar_chain_asserts.sv
`timescale 1ns/1ns
`include "bcc_map.svh"

// Watches the register port and the hold handshake of the calendar chain.
module bcc_calendar_chain_asserts #(
   parameter int DIV = `BCC_COUNT_DIV   // System cycles per count cycle.
) (
   input wire logic               sys_clk,            // System clock.
   input wire logic               rst,                // Asynchronous reset, active high.
   input wire logic [19:0]        regAddr,            // Register byte address.
   input wire logic               regWrite,           // Byte write strobe.
   input wire logic               regRead,            // Byte read strobe.
   input wire bcc_pkg::bcc_byte_t regWdata,           // Write data.
   input wire bcc_pkg::bcc_byte_t regRdata,           // Read data.
   input wire logic               counterRunEnable,   // Counting enabled.
   input wire logic               hourFormatSelect,   // 1 selects 24-hour format.
   input wire logic               counterHoldRequest, // Request to freeze counters.
   input wire logic               counterHoldStatus   // Counters frozen.
);
   import bcc_pkg::*;

   int unsigned holdLag;    // Cycles the status has disagreed with the request.
   bcc_byte_t   readMask;   // Implemented bits of the addressed register.
   logic        addrMapped; // The address names a counter register.

   // Unmapped addresses get an empty mask, so they also read as unmapped.
   assign readMask = (regAddr == `BCC_SEC_ADDR)   ? `BCC_SEC_MASK   :
                     (regAddr == `BCC_MIN_ADDR)   ? `BCC_MIN_MASK   :
                     (regAddr == `BCC_HOUR_ADDR)  ? `BCC_HOUR_MASK  :
                     (regAddr == `BCC_WEEK_ADDR)  ? `BCC_WEEK_MASK  :
                     (regAddr == `BCC_DAY_ADDR)   ? `BCC_DAY_MASK   :
                     (regAddr == `BCC_MONTH_ADDR) ? `BCC_MONTH_MASK :
                     (regAddr == `BCC_YEAR_ADDR)  ? `BCC_YEAR_MASK  : 8'h00;
   assign addrMapped = (readMask != 8'h00);

   // Counts how long the hold status lags its request.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         holdLag <= 0;
      end else if (counterHoldStatus == counterHoldRequest) begin
         holdLag <= 0;
      end else begin
         holdLag <= holdLag + 1;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // A read strobe aimed at one register.
   sequence s_read_at(logic [19:0] addr);
      regRead && (regAddr == addr);
   endsequence

   a_hold_lag_bound: assert property (holdLag <= DIV + 2)
      else $error("hold status lags its request too long");
   a_hold_rise_cause: assert property ($rose(counterHoldStatus) |-> $past(counterHoldRequest))
      else $error("hold status rose without a request");
   a_hold_fall_cause: assert property ($fell(counterHoldStatus) |-> !$past(counterHoldRequest))
      else $error("hold status fell while requested");
   a_unused_bits_zero: assert property (regRead |=> (regRdata & ~$past(readMask)) == 8'h00)
      else $error("unused register bits read as one");
   a_unmapped_read_zero: assert property (regRead && !addrMapped |=> regRdata == 8'h00)
      else $error("unmapped read returned data");
   a_rdata_on_read: assert property ($changed(regRdata) |-> $past(regRead))
      else $error("read data changed without a read");
   a_sec_bcd_range: assert property (s_read_at(`BCC_SEC_ADDR) |=>
      regRdata[3:0] <= 4'h9 && regRdata[6:4] <= 3'h5)
      else $error("seconds left 00 to 59");
   a_min_bcd_range: assert property (s_read_at(`BCC_MIN_ADDR) |=>
      regRdata[3:0] <= 4'h9 && regRdata[6:4] <= 3'h5)
      else $error("minutes left 00 to 59");
   a_week_range: assert property (s_read_at(`BCC_WEEK_ADDR) |=> regRdata <= 8'h06)
      else $error("weekday left 0 to 6");
   a_month_range: assert property (s_read_at(`BCC_MONTH_ADDR) |=>
      regRdata >= 8'h01 && regRdata <= 8'h12 && regRdata[3:0] <= 4'h9)
      else $error("month left 01 to 12");
endmodule

bind bcc_calendar_chain bcc_calendar_chain_asserts #(.DIV(DIV)) u_chk (
   .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
   .regWdata(regWdata), .regRdata(regRdata), .counterRunEnable(counterRunEnable),
   .hourFormatSelect(hourFormatSelect), .counterHoldRequest(counterHoldRequest),
   .counterHoldStatus(counterHoldStatus));

// ### test_bcc_calendar_chain.sv
`timescale 1ns/1ns
`include "bcc_map.svh"

// Drives the calendar chain through its register port and control pins.
module test_bcc_calendar_chain;
   import bcc_pkg::*;

   localparam int DIV = 1;        // A tick every cycle; one second is 32768 cycles.
   logic        sys_clk;          // System clock.
   logic        rst;              // Reset, active high.
   logic [19:0] regAddr;          // Register address.
   logic        regWrite;         // Write strobe.
   logic        regRead;          // Read strobe.
   bcc_byte_t   regWdata;         // Write data.
   bcc_byte_t   regRdata;         // Read data.
   logic        runEn;            // Counting enabled.
   logic        fmt;              // 24-hour format.
   logic        hold;             // Hold request.
   logic        holdSt;           // Hold status.
   int          err_count = 0;    // Mismatches seen.
   int          total_checks = 0; // Comparisons made.
   int          cyc = 0;          // Free-running cycle count.
   int          c0;               // Cycle at which the last second started.
   bcc_byte_t   rd;               // Last value read.
   logic [19:0] addrs [7] = '{`BCC_SEC_ADDR, `BCC_MIN_ADDR, `BCC_HOUR_ADDR, `BCC_WEEK_ADDR,
                              `BCC_DAY_ADDR, `BCC_MONTH_ADDR, `BCC_YEAR_ADDR};
   bcc_byte_t   rstv [7] = '{8'h00, 8'h00, 8'h12, 8'h00, 8'h01, 8'h01, 8'h00};
   bcc_byte_t   setv [7] = '{8'h59, 8'h59, 8'h23, 8'h06, 8'h31, 8'h12, 8'h99};
   bcc_byte_t   endv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
   bcc_byte_t   h12  [6] = '{8'h12, 8'h01, 8'h11, 8'h32, 8'h21, 8'h31};
   bcc_byte_t   h24  [6] = '{8'h00, 8'h01, 8'h11, 8'h12, 8'h13, 8'h23};
   bcc_byte_t   leapv [7] = '{8'h59, 8'h59, 8'h23, 8'h03, 8'h28, 8'h02, 8'h04}; // Feb 28.
   bcc_byte_t   leape [7] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h29, 8'h02, 8'h04}; // Feb 29.

   bcc_calendar_chain #(.DIV(DIV)) dut (
      .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
      .regWdata(regWdata), .regRdata(regRdata), .counterRunEnable(runEn),
      .hourFormatSelect(fmt), .counterHoldRequest(hold), .counterHoldStatus(holdSt));

   // Clock and cycle counter.
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) cyc <= cyc + 1;

   // Compares one value and reports a mismatch.
   task automatic check(string what, bcc_byte_t seen, bcc_byte_t exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One-cycle byte write.
   task automatic wr(logic [19:0] a, bcc_byte_t d);
      @(posedge sys_clk); #1;
      regAddr = a; regWdata = d; regWrite = 1'b1;
      @(posedge sys_clk); #1;
      regWrite = 1'b0;
   endtask

   // One-cycle byte read; the data is taken one cycle after the strobe.
   task automatic rdb(logic [19:0] a);
      @(posedge sys_clk); #1;
      regAddr = a; regRead = 1'b1;
      @(posedge sys_clk); #1;
      regRead = 1'b0; rd = regRdata;
   endtask

   task automatic rdchk(string what, logic [19:0] a, bcc_byte_t exp);
      rdb(a);
      check(what, rd, exp);
   endtask

   task automatic idle(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      rst = 1'b1; regAddr = '0; regWrite = 1'b0; regRead = 1'b0; regWdata = 8'h00;
      runEn = 1'b0; fmt = 1'b0; hold = 1'b0;
      idle(4);
      rst = 1'b0;
      runEn = 1'b1;
      for (int i = 0; i < 7; i++) rdchk("reset value", addrs[i], rstv[i]);
      rdchk("unmapped", 20'hFFF99, 8'h00);
      wr(`BCC_DAY_ADDR, 8'hC5);
      idle(2 * DIV);
      rdchk("day mask", `BCC_DAY_ADDR, 8'h05);
      fmt = 1'b1;
      idle(2 * DIV + 2);
      rdchk("hour 24h after reset", `BCC_HOUR_ADDR, 8'h00);
      // Each hour written in 12-hour form must convert both ways.
      for (int i = 0; i < 6; i++) begin
         fmt = 1'b0;
         idle(2 * DIV + 2);
         wr(`BCC_HOUR_ADDR, h12[i]);
         idle(2 * DIV);
         rdchk("hour 12h", `BCC_HOUR_ADDR, h12[i]);
         fmt = 1'b1;
         idle(2 * DIV + 2);
         rdchk("hour to 24h", `BCC_HOUR_ADDR, h24[i]);
         fmt = 1'b0;
         idle(2 * DIV + 2);
         rdchk("hour to 12h", `BCC_HOUR_ADDR, h12[i]);
      end
      hold = 1'b1;
      idle(DIV + 2);
      check("hold status set", {7'h00, holdSt}, 8'h01);
      hold = 1'b0;
      idle(DIV + 2);
      check("hold status clear", {7'h00, holdSt}, 8'h00);
      // Last second of a year, seconds written last to clear the prescaler.
      fmt = 1'b1;
      idle(2 * DIV + 2);
      for (int i = 6; i >= 0; i--) wr(addrs[i], setv[i]);
      c0 = cyc;
      idle(2 * DIV);
      rd = 8'h59;
      for (int n = 0; rd === 8'h59; n++) begin
         if (n == 20000) begin
            err_count++;        // A second that never ends counts as a mismatch.
            break;
         end
         if (n == 5000) begin
            runEn = 1'b0;
            idle(2000);
            runEn = 1'b1;
         end
         rdb(`BCC_SEC_ADDR);
      end
      check("second length", {7'h00, (cyc - c0) inside {[32768 * DIV + 1992:32768 * DIV + 2012]}},
            8'h01);
      idle(2 * DIV);
      for (int i = 0; i < 7; i++) rdchk("rollover", addrs[i], endv[i]);
      // Leap February; a hold covers the overflow that ends the day, which must wait for release.
      for (int i = 6; i >= 0; i--) wr(addrs[i], leapv[i]);
      idle(32760);
      hold = 1'b1;
      idle(40);
      rdchk("held seconds", `BCC_SEC_ADDR, 8'h59);
      hold = 1'b0;
      idle(4);
      for (int i = 0; i < 7; i++) rdchk("leap day", addrs[i], leape[i]);
      tally_and_finish;
   end
endmodule
